// ### include/dcs_pkg.sv
package dcs_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned ADDR_W                = 6;
  localparam logic [5:0]  ADDR_LOW_SPEED_FLAG   = 6'h20;
  localparam logic [5:0]  ADDR_CLOCK_SEL_PRI    = 6'h27;
  localparam logic [5:0]  ADDR_CLOCK_DIV_SEL    = 6'h28;
  localparam logic [1:0]  LOW_SPEED_BIT         = 2'h0;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned POS_SUBCLOCK_STOP     = 3;
  localparam int unsigned POS_SUBCLOCK_DIV      = 2;
  localparam int unsigned POS_MAIN_FREQ_RANGE   = 1;
  localparam int unsigned POS_MAIN_DIV_LOW      = 0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic        RST_SUBCLOCK_STOP     = 1'h0;
  localparam logic        RST_SUBCLOCK_DIV      = 1'h0;
  localparam logic        RST_MAIN_FREQ_RANGE   = 1'h0;
  localparam logic [1:0]  RST_MAIN_DIV          = 2'h0;
  localparam logic        RST_LOW_SPEED         = 1'h0;

  // ****************************************
  // divisor counts
  // ****************************************
  localparam int unsigned DIV_W                 = 6;
  localparam logic [5:0]  MAIN_DIV_BASE         = 6'h04;
  localparam logic [5:0]  SUB_DIV_SLOW          = 6'h08;
  localparam logic [5:0]  SUB_DIV_FAST          = 6'h04;
  localparam logic [5:0]  WATCH_DIV             = 6'h08;

  // ****************************************
  // operating modes
  // ****************************************
  typedef enum logic [1:0] {
    MODE_ACTIVE    = 2'b00,
    MODE_WATCH     = 2'b01,
    MODE_SUBACTIVE = 2'b10,
    MODE_STOP      = 2'b11
  } dcs_mode_t;

endpackage

// ### logic/dcs_sync2.sv
`timescale 1ns/100ps
module dcs_sync2
  import dcs_pkg::*;
#(
  parameter int unsigned WIDTH = 2
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  if (WIDTH < 1) begin : g_width_check
    $error("dcs_sync2: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } dcs_sync_state_t;

  dcs_sync_state_t st;
  dcs_sync_state_t next_st;

  always_comb begin
    next_st.stage1 = asyncIn;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign syncOut = st.stage2;

endmodule

// ### logic/dcs_tick_div.sv
`timescale 1ns/100ps
module dcs_tick_div
  import dcs_pkg::*;
#(
  parameter int unsigned CNT_W = DIV_W
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // control
  input  wire logic             clear,
  input  wire logic [CNT_W-1:0] modulus,
  // ticks
  input  wire logic             inTick,
  output logic                  outTick
);

  if (CNT_W < 2) begin : g_width_check
    $error("dcs_tick_div: CNT_W must be at least 2");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } dcs_div_state_t;

  dcs_div_state_t st;
  dcs_div_state_t next_st;

  // one output tick per modulus input ticks
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (clear) begin
      next_st.cnt = '0;
    end else if (inTick) begin
      if (st.cnt >= CNT_W'(modulus - CNT_W'(1))) begin
        next_st.cnt  = '0;
        next_st.tick = 1'b1;
      end else begin
        next_st.cnt = CNT_W'(st.cnt + CNT_W'(1));
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign outTick = st.tick;

endmodule

// ### logic/dcs_clock_select.sv
`timescale 1ns/100ps
module dcs_clock_select
  import dcs_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // oscillator pins
  input  wire logic              mainOscPin,
  input  wire logic              subOscPin,
  // register word write
  input  wire logic              regWrEn,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [3:0]        regWrData,
  // register flag bit operations
  input  wire logic              bitSet,
  input  wire logic              bitClr,
  input  wire logic              bitTest,
  input  wire logic [1:0]        bitNum,
  output logic                   bitTestData,
  // mode requests
  input  wire logic              watchReq,
  input  wire logic              stopReq,
  input  wire logic              wakeReq,
  input  wire logic              activeReq,
  // clock outputs
  output dcs_mode_t              mode,
  output logic                   instrTick,
  output logic                   mainPrescalerTick,
  output logic                   watchPrescalerTick,
  output logic                   mainOscRun,
  output logic                   subOscRun,
  // control readback
  output logic [1:0]             effMainDiv,
  output logic                   lowSpeedFlag
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    dcs_mode_t  mode;
    logic       lowSpeed;
    logic       stopSel;
    logic       subDiv;
    logic       freqRange;
    logic [1:0] pendDiv;
    logic [1:0] effDiv;
    logic [1:0] oscPrev;
    logic       instrTick;
    logic       mainPsTick;
    logic       watchTick;
    logic       mainRun;
    logic       subRun;
    logic       testData;
  } dcs_top_state_t;

  dcs_top_state_t st;
  dcs_top_state_t next_st;

  logic [1:0]       oscSync;
  logic             mainEdge;
  logic             subEdge;
  logic             mainDivTick;
  logic             subCpuTick;
  logic             watchDivTick;
  logic [DIV_W-1:0] mainModulus;
  logic [DIV_W-1:0] subModulus;
  logic             flagHit;

  // ****************************************
  // oscillator pin synchronisers and edges
  // ****************************************
  dcs_sync2 #(.WIDTH(2)) uSync (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .asyncIn ({subOscPin, mainOscPin}),
    .syncOut (oscSync)
  );

  assign mainEdge = oscSync[0] & ~st.oscPrev[0];
  assign subEdge  = oscSync[1] & ~st.oscPrev[1];

  // ****************************************
  // dividers
  // ****************************************
  // divisor decode
  assign mainModulus = DIV_W'(MAIN_DIV_BASE << st.effDiv);
  assign subModulus  = st.subDiv ? SUB_DIV_FAST : SUB_DIV_SLOW;

  // main clock stands still outside active mode
  dcs_tick_div #(.CNT_W(DIV_W)) uMainDiv (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .clear   (st.mode != MODE_ACTIVE),
    .modulus (mainModulus),
    .inTick  (mainEdge),
    .outTick (mainDivTick)
  );

  dcs_tick_div #(.CNT_W(DIV_W)) uSubDiv (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .clear   (st.mode != MODE_SUBACTIVE),
    .modulus (subModulus),
    .inTick  (subEdge),
    .outTick (subCpuTick)
  );

  dcs_tick_div #(.CNT_W(DIV_W)) uWatchDiv (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .clear   (!st.subRun),
    .modulus (WATCH_DIV),
    .inTick  (subEdge),
    .outTick (watchDivTick)
  );

  assign flagHit = (regAddr == ADDR_LOW_SPEED_FLAG) && (bitNum == LOW_SPEED_BIT);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st         = st;
    next_st.oscPrev = oscSync;

    if (st.mode != MODE_STOP && flagHit && bitSet) begin
      next_st.lowSpeed = 1'b1;
    end else if (st.mode != MODE_STOP && flagHit && bitClr) begin
      next_st.lowSpeed = 1'b0;
    end
    next_st.testData = (bitTest && flagHit) ? st.lowSpeed : 1'b0;

    if (regWrEn && st.mode != MODE_STOP) begin
      if (regAddr == ADDR_CLOCK_SEL_PRI) begin
        next_st.stopSel   = regWrData[POS_SUBCLOCK_STOP];
        next_st.subDiv    = regWrData[POS_SUBCLOCK_DIV];
        next_st.freqRange = regWrData[POS_MAIN_FREQ_RANGE];
      end else if (regAddr == ADDR_CLOCK_DIV_SEL) begin
        next_st.pendDiv = regWrData[POS_MAIN_DIV_LOW +: 2];
      end
    end

    case (st.mode)
      MODE_ACTIVE: begin
        if (stopReq) begin
          next_st.mode = MODE_STOP;
        end else if (watchReq) begin
          next_st.mode = MODE_WATCH;
        end
      end
      MODE_WATCH: begin
        if (wakeReq) begin
          next_st.mode = st.lowSpeed ? MODE_SUBACTIVE : MODE_ACTIVE;
        end
      end
      MODE_SUBACTIVE: begin
        if (watchReq) begin
          next_st.mode = MODE_WATCH;
        end else if (activeReq && !st.lowSpeed) begin
          next_st.mode = MODE_ACTIVE;
        end
      end
      MODE_STOP: begin
        if (wakeReq) begin
          next_st.mode = MODE_ACTIVE;
        end
      end
      default: begin
        next_st.mode = MODE_ACTIVE;
      end
    endcase

    if (next_st.mode == MODE_STOP && st.mode != MODE_STOP) begin
      next_st.subDiv    = RST_SUBCLOCK_DIV;
      next_st.freqRange = RST_MAIN_FREQ_RANGE;
      next_st.pendDiv   = RST_MAIN_DIV;
      next_st.stopSel   = st.stopSel;
    end

    // divisor loads on return to active
    if (next_st.mode == MODE_ACTIVE && st.mode != MODE_ACTIVE) begin
      next_st.effDiv = st.pendDiv;
    end

    // one divided main period is one cycle
    next_st.instrTick  = (st.mode == MODE_ACTIVE) ? mainDivTick : subCpuTick;
    next_st.mainPsTick = (st.mode == MODE_ACTIVE) && mainDivTick;
    next_st.watchTick  = watchDivTick;
    next_st.mainRun    = (next_st.mode == MODE_ACTIVE);
    next_st.subRun     = !(next_st.mode == MODE_STOP && next_st.stopSel);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st           <= '0;
      st.mode      <= MODE_ACTIVE;
      st.lowSpeed  <= RST_LOW_SPEED;
      st.stopSel   <= RST_SUBCLOCK_STOP;
      st.subDiv    <= RST_SUBCLOCK_DIV;
      st.freqRange <= RST_MAIN_FREQ_RANGE;
      st.pendDiv   <= RST_MAIN_DIV;
      st.effDiv    <= RST_MAIN_DIV;
      st.mainRun   <= 1'b1;
      st.subRun    <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign mode               = st.mode;
  assign instrTick          = st.instrTick;
  assign mainPrescalerTick  = st.mainPsTick;
  assign watchPrescalerTick = st.watchTick;
  assign mainOscRun         = st.mainRun;
  assign subOscRun          = st.subRun;
  assign effMainDiv         = st.effDiv;
  assign lowSpeedFlag       = st.lowSpeed;
  assign bitTestData        = st.testData;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_enter_stop;
    st.mode != MODE_STOP ##1 st.mode == MODE_STOP;
  endsequence

  sequence s_return_active;
    st.mode != MODE_ACTIVE ##1 st.mode == MODE_ACTIVE;
  endsequence

  property p_stop_clear;
    s_enter_stop |-> !st.subDiv && !st.freqRange;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop entry left fields set");

  property p_subosc_stop;
    st.mode == MODE_STOP |-> (subOscRun == !st.stopSel);
  endproperty
  a_subosc_stop: assert property (p_subosc_stop) else $error("subsystem run wrong in stop");

  property p_stopsel_kept;
    s_enter_stop |-> st.stopSel == $past(st.stopSel, 1);
  endproperty
  a_stopsel_kept: assert property (p_stopsel_kept) else $error("stop entry changed stop bit");

  property p_sub_modulus;
    st.mode == MODE_SUBACTIVE |-> subModulus == (st.subDiv ? SUB_DIV_FAST : SUB_DIV_SLOW);
  endproperty
  a_sub_modulus: assert property (p_sub_modulus) else $error("subactive divisor wrong");

  property p_watch_spacing;
    watchPrescalerTick |=> !watchPrescalerTick [*7];
  endproperty
  a_watch_spacing: assert property (p_watch_spacing) else $error("watch ticks too close");

  property p_div_stop_clear;
    s_enter_stop |-> st.pendDiv == 2'h0;
  endproperty
  a_div_stop_clear: assert property (p_div_stop_clear) else $error("divisor not cleared");

  property p_main_mute;
    st.mode != MODE_ACTIVE [*3] |-> !mainPrescalerTick;
  endproperty
  a_main_mute: assert property (p_main_mute) else $error("main tick outside active");

  property p_div_hold;
    $changed(st.effDiv) |-> st.mode == MODE_ACTIVE && $past(st.mode) != MODE_ACTIVE;
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divisor changed early");

  property p_active_write;
    st.mode == MODE_ACTIVE && regWrEn && regAddr == ADDR_CLOCK_DIV_SEL && !stopReq
      && !watchReq |=> $stable(st.effDiv);
  endproperty
  a_active_write: assert property (p_active_write) else $error("active write took effect");

  property p_return_load;
    s_return_active |-> st.effDiv == $past(st.pendDiv, 1);
  endproperty
  a_return_load: assert property (p_return_load) else $error("divisor not loaded");

  property p_wake_select;
    st.mode == MODE_WATCH && wakeReq |=>
      st.mode == ($past(st.lowSpeed) ? MODE_SUBACTIVE : MODE_ACTIVE);
  endproperty
  a_wake_select: assert property (p_wake_select) else $error("wake chose wrong clock");

endmodule

// ### tb/dcs_testbench.sv
`timescale 1ns/100ps
module testbench
  import dcs_pkg::*;
();
  // ****************************************
  // design signals
  // ****************************************
  logic              mclk;
  logic              rst_b;
  logic              mainOscPin;
  logic              subOscPin;
  logic              regWrEn;
  logic [ADDR_W-1:0] regAddr;
  logic [3:0]        regWrData;
  logic              bitSet;
  logic              bitClr;
  logic              bitTest;
  logic [1:0]        bitNum;
  logic              bitTestData;
  logic              watchReq;
  logic              stopReq;
  logic              wakeReq;
  logic              activeReq;
  dcs_mode_t         mode;
  logic              instrTick;
  logic              mainPrescalerTick;
  logic              watchPrescalerTick;
  logic              mainOscRun;
  logic              subOscRun;
  logic [1:0]        effMainDiv;
  logic              lowSpeedFlag;
  int                errorCnt;
  int                nTests;
  int                cyc;
  int                mainCnt;
  int                subCnt;
  int                n;

  dcs_clock_select u_dcs_clock_select (
    .mclk(mclk), .rst_b(rst_b), .mainOscPin(mainOscPin), .subOscPin(subOscPin),
    .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
    .bitSet(bitSet), .bitClr(bitClr), .bitTest(bitTest), .bitNum(bitNum),
    .bitTestData(bitTestData), .watchReq(watchReq), .stopReq(stopReq),
    .wakeReq(wakeReq), .activeReq(activeReq), .mode(mode), .instrTick(instrTick),
    .mainPrescalerTick(mainPrescalerTick), .watchPrescalerTick(watchPrescalerTick),
    .mainOscRun(mainOscRun), .subOscRun(subOscRun), .effMainDiv(effMainDiv),
    .lowSpeedFlag(lowSpeedFlag)
  );

  // ****************************************
  // clock, oscillators, watchdog
  // ****************************************
  always #20 mclk = ~mclk;

  // main rises every 4 mclk, subsystem every 6 mclk
  always @(negedge mclk) begin
    mainCnt <= mainCnt + 1;
    if (mainCnt % 2 == 1) mainOscPin <= ~mainOscPin;
    subCnt <= subCnt + 1;
    if (subCnt % 3 == 2) subOscPin <= ~subOscPin;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errorCnt++;
      closeOut();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic closeOut;
    $display("errors %0d, checks %0d", errorCnt, nTests);
    if (errorCnt == 0 && nTests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      errorCnt++;
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [3:0] d);
    @(negedge mclk);
    regWrEn   = 1'b1;
    regAddr   = a;
    regWrData = d;
    @(negedge mclk);
    regWrEn   = 1'b0;
  endtask

  // 0 watch, 1 stop, 2 wake, 3 active
  task automatic req(input int k);
    @(negedge mclk);
    watchReq  = (k == 0);
    stopReq   = (k == 1);
    wakeReq   = (k == 2);
    activeReq = (k == 3);
    @(negedge mclk);
    {watchReq, stopReq, wakeReq, activeReq} = 4'h0;
  endtask

  // 0 set, 1 clear, 2 test
  task automatic bop(input int k);
    @(negedge mclk);
    regAddr = ADDR_LOW_SPEED_FLAG;
    bitNum  = LOW_SPEED_BIT;
    bitSet  = (k == 0);
    bitClr  = (k == 1);
    bitTest = (k == 2);
    @(negedge mclk);
    {bitSet, bitClr, bitTest} = 3'h0;
  endtask

  function automatic logic tk(input int w);
    case (w)
      0:       return instrTick === 1'b1;
      1:       return mainPrescalerTick === 1'b1;
      default: return watchPrescalerTick === 1'b1;
    endcase
  endfunction

  // cycles between two consecutive pulses of the chosen tick
  task automatic period(input int w, output int p);
    int k;
    k = 0;
    while (!tk(w) && k < 2000) begin
      @(negedge mclk);
      k++;
    end
    @(negedge mclk);
    p = 1;
    while (!tk(w) && p < 2000) begin
      @(negedge mclk);
      p++;
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    {mainOscPin, subOscPin, regWrEn, bitSet, bitClr, bitTest} = 6'h00;
    {watchReq, stopReq, wakeReq, activeReq} = 4'h0;
    regAddr = 6'h00;
    regWrData = 4'h0;
    bitNum = 2'h0;
    {errorCnt, nTests, cyc, mainCnt, subCnt} = '0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    @(negedge mclk);
    chk(32'(mode), 32'(MODE_ACTIVE));
    chk(32'({mainOscRun, subOscRun}), 32'h3);
    chk(32'({effMainDiv, lowSpeedFlag}), 32'h0);
    period(2, n);
    chk(32'(n), 32'h30);
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_CLOCK_DIV_SEL, 4'(d));
      chk(32'(effMainDiv), 32'(d == 0 ? 0 : d - 1));
      req(0);
      chk(32'({mode, mainOscRun}), 32'({MODE_WATCH, 1'b0}));
      req(2);
      chk(32'({mode, effMainDiv}), 32'({MODE_ACTIVE, 2'(d)}));
      chk(32'(mainOscRun), 32'h1);
      period(0, n);
      chk(32'(n), 32'(16 << d));
      period(1, n);
      chk(32'(n), 32'(16 << d));
    end
    wr(6'h29, 4'h1);
    wr(ADDR_LOW_SPEED_FLAG, 4'hF);
    req(0);
    req(2);
    chk(32'(effMainDiv), 32'h3);
    chk(32'(lowSpeedFlag), 32'h0);
    // subactive with fast subsystem divisor
    wr(ADDR_CLOCK_SEL_PRI, 4'h4);
    bop(0);
    chk(32'(lowSpeedFlag), 32'h1);
    bop(2);
    chk(32'(bitTestData), 32'h1);
    @(negedge mclk);
    chk(32'(bitTestData), 32'h0);
    req(0);
    req(2);
    chk(32'(mode), 32'(MODE_SUBACTIVE));
    period(0, n);
    chk(32'(n), 32'h18);
    period(2, n);
    chk(32'(n), 32'h30);
    wr(ADDR_CLOCK_DIV_SEL, 4'h1);
    bop(1);
    req(3);
    chk(32'({mode, effMainDiv}), 32'({MODE_ACTIVE, 2'h1}));
    // stop entry clears fields, keeps the stop-setting bit
    wr(ADDR_CLOCK_SEL_PRI, 4'hC);
    wr(ADDR_CLOCK_DIV_SEL, 4'h2);
    req(1);
    chk(32'({mode, subOscRun}), 32'({MODE_STOP, 1'b0}));
    wr(ADDR_CLOCK_DIV_SEL, 4'h3);
    req(2);
    chk(32'({mode, effMainDiv}), 32'({MODE_ACTIVE, 2'h0}));
    chk(32'(subOscRun), 32'h1);
    bop(0);
    req(0);
    req(2);
    period(0, n);
    chk(32'(n), 32'h30);
    bop(1);
    req(3);
    chk(32'(mode), 32'(MODE_ACTIVE));
    req(1);
    chk(32'(subOscRun), 32'h0);
    req(2);
    wr(ADDR_CLOCK_SEL_PRI, 4'h0);
    req(1);
    chk(32'({mode, subOscRun}), 32'({MODE_STOP, 1'b1}));
    req(2);
    chk(32'(mode), 32'(MODE_ACTIVE));
    closeOut();
  end
endmodule
